// file: common/tlc_pkg.sv
// constants for the timer hardware-limit control block
package tlc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_LIMIT_CTRL = 8'h00;
   localparam logic [7:0] OFS_RUN_CTRL = 8'h04;
   localparam logic [7:0] OFS_PERIOD = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0c;
   localparam logic [7:0] OFS_RESET_SRC = 8'h10;
   // field positions of timer_limit_control
   localparam int BIT_PRESCALER_SYNC_SELECT = 7;
   localparam int BIT_CLOCK_EDGE_SELECT = 6;
   localparam int BIT_ENABLE_SYNC_SELECT = 5;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 5;
   // mode field bits used by this block
   localparam int MODE_BIT_ONESHOT = 3;
   localparam int MODE_BIT_EXTRST = 2;
   localparam int BIT_RUN = 0;
   localparam int RSRC_W = 4;
   // reset values
   localparam logic [7:0] RST_LIMIT_CTRL = 8'h00;
   localparam logic [7:0] RST_PERIOD = 8'hff;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [3:0] RST_RESET_SRC = 4'h0;
   // external reset source codes
   localparam logic [3:0] RSRC_PIN = 4'h0;
   localparam logic [3:0] RSRC_RESERVED = 4'hf;
   // instruction clock is the system clock divided by four
   localparam int INSTR_DIV = 4;
   localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// file: rtl/tlc_sync2.sv
// two-flop synchroniser for pin-side levels
`timescale 1ns/1ps
module tlc_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // first stage is read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // tlc_sync2

// file: rtl/tlc_timer_limit.sv
// timer hardware-limit control with apb registers
//
// Overview of operation
// - With prescaler sync set, each input tick waits for the next instruction-clock enable (pclk/4); else it is used at once.
// - Clock edge select picks counting on the rising (0) or falling (1) edge of the input clock.
// - With prescaler sync set the timer does not count in sleep, and the count read back is always a settled value.
// - With enable sync set, run-enable passes two input-clock stages, so counting starts two input clocks later, glitch-free.
// - Every mode starts when run-enable goes to 1 and stops when it goes to 0, leaving the count unchanged.
// - In one-shot modes hardware clears run-enable by itself on a period match.
// - Once the count equals the period value, the next timer clock clears the count to zero, in every mode.
// - While run-enable is 0 the prescaler pending stage is held clear; with enable sync set and prescaler sync off the count stops only two input clocks later.
// - The external reset comes from a 4-bit source field: 0000 is the dedicated pin, 1111 is reserved.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module tlc_timer_limit (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer input clock and external reset pin
   input wire logic timer_input_clock,
   input wire logic ext_reset_pin,
   // on-chip reset sources, codes 1 to 14
   input wire logic [14:1] ext_reset_src,
   input wire logic sleep_mode,
   // status
   output logic [7:0] count_value,
   output logic period_match
);
   logic [7:0] limit_ctrl_q;
   logic run_en_q;
   logic [7:0] period_q;
   logic [3:0] rsrc_q;
   logic [1:0] pin_sync;
   logic clk_d_q;
   logic [1:0] div_q;
   logic instr_en;
   logic edge_hit;
   logic pend_q;
   logic tick;
   logic en_s1_q;
   logic en_s2_q;
   logic running;
   logic ext_hit;
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic [31:0] rd_d;
   logic at_period;
   logic oneshot;
   logic ctrl_wr;

   wire prescaler_sync_select = limit_ctrl_q[tlc_pkg::BIT_PRESCALER_SYNC_SELECT];
   wire clock_edge_select = limit_ctrl_q[tlc_pkg::BIT_CLOCK_EDGE_SELECT];
   wire enable_sync_select = limit_ctrl_q[tlc_pkg::BIT_ENABLE_SYNC_SELECT];
   wire [4:0] mode =
      limit_ctrl_q[tlc_pkg::MODE_LSB +: tlc_pkg::MODE_W];

   tlc_sync2 #(.W(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({ext_reset_pin, timer_input_clock}),
      .sync_out(pin_sync)
   );

   // apb decode
   assign wr_en = psel & penable & pwrite & pready;
   assign rd_setup = psel & ~penable;
   assign ctrl_wr = wr_en & (paddr == tlc_pkg::OFS_RUN_CTRL);
   always_comb begin
      mapped = 1'b1;
      rd_d = tlc_pkg::READ_ZERO;
      case (paddr)
         tlc_pkg::OFS_LIMIT_CTRL: rd_d[7:0] = limit_ctrl_q;
         tlc_pkg::OFS_RUN_CTRL: rd_d[tlc_pkg::BIT_RUN] = run_en_q;
         tlc_pkg::OFS_PERIOD: rd_d[7:0] = period_q;
         tlc_pkg::OFS_COUNT: rd_d[7:0] = count_value;
         tlc_pkg::OFS_RESET_SRC: rd_d[3:0] = rsrc_q;
         default: mapped = 1'b0;
      endcase
   end

   // zero-wait answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= tlc_pkg::READ_ZERO;
      end else begin
         pready <= rd_setup;
         pslverr <= rd_setup & ~mapped;
         if (rd_setup && !pwrite) begin
            prdata <= rd_d;
         end
      end
   end

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_ctrl_q <= tlc_pkg::RST_LIMIT_CTRL;
         period_q <= tlc_pkg::RST_PERIOD;
         rsrc_q <= tlc_pkg::RST_RESET_SRC;
      end else if (wr_en) begin
         case (paddr)
            tlc_pkg::OFS_LIMIT_CTRL: limit_ctrl_q <= pwdata[7:0];
            tlc_pkg::OFS_PERIOD: period_q <= pwdata[7:0];
            tlc_pkg::OFS_RESET_SRC: rsrc_q <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // a software write in the same cycle overrides the hardware clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_en_q <= 1'b0;
      end else if (ctrl_wr) begin
         run_en_q <= pwdata[tlc_pkg::BIT_RUN];
      end else if (period_match && oneshot) begin
         run_en_q <= 1'b0;
      end
   end

   // instruction clock enable
   assign instr_en = (div_q == tlc_pkg::INSTR_LAST);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 2'h0;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end

   // input clock edge; edge select must stay put while running
   assign edge_hit = clock_edge_select ? (clk_d_q & ~pin_sync[0])
                           : (~clk_d_q & pin_sync[0]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_d_q <= 1'b0;
      end else begin
         clk_d_q <= pin_sync[0];
      end
   end

   // pending edge waits for the instruction enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
      end else if (!run_en_q || !prescaler_sync_select) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= edge_hit | (pend_q & ~instr_en);
      end
   end
   always_comb begin
      if (prescaler_sync_select) begin
         tick = pend_q & instr_en & ~sleep_mode;
      end else begin
         tick = edge_hit;
      end
   end

   // run-enable carried over two input clocks; also delays the stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
      end else if (!enable_sync_select) begin
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
      end else if (edge_hit) begin
         en_s1_q <= run_en_q;
         en_s2_q <= en_s1_q;
      end
   end
   assign running = enable_sync_select ? en_s2_q : run_en_q;

   // external reset source; reserved code never resets
   always_comb begin
      if (rsrc_q == tlc_pkg::RSRC_PIN) begin
         ext_hit = pin_sync[1];
      end else if (rsrc_q == tlc_pkg::RSRC_RESERVED) begin
         ext_hit = 1'b0;
      end else begin
         ext_hit = ext_reset_src[rsrc_q];
      end
      ext_hit = ext_hit & mode[tlc_pkg::MODE_BIT_EXTRST];
   end

   assign oneshot = mode[tlc_pkg::MODE_BIT_ONESHOT];
   assign at_period = (count_value == period_q);

   // counter; stopping keeps the value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value <= tlc_pkg::RST_COUNT;
         period_match <= 1'b0;
      end else begin
         period_match <= 1'b0;
         if (!running) begin
            count_value <= count_value;
         end else if (ext_hit) begin
            count_value <= tlc_pkg::RST_COUNT;
         end else if (tick && at_period) begin
            count_value <= tlc_pkg::RST_COUNT;
            period_match <= 1'b1;
         end else if (tick) begin
            count_value <= count_value + 8'h01;
         end
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_apb_ready: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   a_apb_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access without error");
   a_prescaler_sync_select_align: assert property (prescaler_sync_select && tick |-> instr_en)
      else $error("synced tick off the instruction enable");
   a_prescaler_sync_select_no_loss: assert property (
      prescaler_sync_select && run_en_q && edge_hit && !sleep_mode
      |-> ##[0:4] (tick || sleep_mode || !run_en_q || !prescaler_sync_select))
      else $error("synced edge never reached the counter");
   a_sleep_stall: assert property (prescaler_sync_select && sleep_mode |-> !tick)
      else $error("tick in sleep with prescaler sync");
   a_enable_sync_gate: assert property (
      enable_sync_select && edge_hit
      |=> en_s1_q == $past(run_en_q) && en_s2_q == $past(en_s1_q))
      else $error("run-enable stages did not shift on the input edge");
   a_stop_hold: assert property (!running |=> $stable(count_value))
      else $error("count moved while stopped");
   a_oneshot_clear: assert property (
      period_match && oneshot && !ctrl_wr |=> !run_en_q)
      else $error("one-shot left run-enable set");
   a_period_clear: assert property (
      running && tick && at_period && !ext_hit
      |=> count_value == 8'h00 && period_match)
      else $error("count not cleared after match");
   a_count_step: assert property (
      running && tick && !at_period && !ext_hit
      |=> count_value == $past(count_value) + 8'h01)
      else $error("count failed to step");
   a_reserved_src: assert property (
      rsrc_q == tlc_pkg::RSRC_RESERVED |-> !ext_hit)
      else $error("reserved source caused reset");
   a_off_stages: assert property (!run_en_q |=> !pend_q)
      else $error("prescaler stage live while off");

   c_match: cover property (running && period_match);
   c_oneshot: cover property (period_match && oneshot ##1 !run_en_q);
   c_ext_reset: cover property (running && ext_hit);
   c_sync_start: cover property (enable_sync_select && $rose(running));
endmodule // tlc_timer_limit

// file: sim/testbench.sv
// self-checking bench for the timer hardware-limit control block
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic timer_input_clock, ext_reset_pin, sleep_mode, period_match;
   logic [7:0] paddr, count_value;
   logic [31:0] pwdata, prdata, d;
   logic [14:1] ext_reset_src;
   logic [3:0] src;
   int err_count, check_count, cyc, cnt, per, pm_exp, pm_seen, hold;
   bit run, pol, prescaler_sync_select, slp, osh, xrst, esync;
   logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   logic [31:0] rv [5] = '{32'h0, 32'h0, 32'hff, 32'h0, 32'h0};

   tlc_timer_limit u_tlc_timer_limit (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_input_clock(timer_input_clock),
      .ext_reset_pin(ext_reset_pin), .ext_reset_src(ext_reset_src),
      .sleep_mode(sleep_mode), .count_value(count_value),
      .period_match(period_match));

   initial begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end

   // the pulse is one cycle wide, so every edge is looked at
   always @(posedge pclk) begin
      cyc++;
      if (period_match === 1'b1) pm_seen++;
      if (cyc == 12000) begin
         err_count++;
         conclude();
      end
   end

   task conclude;
      if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic ee);
      logic [31:0] r;
      logic er;
      apb(1'b0, a, 32'h0, r, er);
      chk("prdata", e, r);
      chk("pslverr", {31'h0, ee}, {31'h0, er});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] r;
      logic er;
      apb(1'b1, a, v, r, er);
   endtask

   task cfg(input logic [7:0] v);
      wr(8'h00, {24'h0, v});
      prescaler_sync_select = v[7];
      pol = v[6];
      esync = v[5];
      osh = v[3];
      xrst = v[2];
   endtask

   // with enable sync, the first two input edges only fill the stages
   task setrun(input bit b);
      wr(8'h04, {31'h0, b});
      if (b && !run && esync) hold = 2;
      run = b;
   endtask

   // one input-clock edge, then the model is compared with the count
   // only the selected edge moves the enable stages or steps the count; the external reset clears it on either edge
   task tick;
      bit e;
      @(posedge pclk);
      timer_input_clock <= ~timer_input_clock;
      e = run && ((~timer_input_clock) != pol);
      if (e && hold > 0) hold--;
      else if (e && !(prescaler_sync_select && slp)) begin
         if (cnt == per) begin
            cnt = 0;
            pm_exp++;
            if (osh) run = 0;
         end else cnt++;
      end
      if (run && xrst && (src == 4'h0 ? ext_reset_pin === 1'b1
          : (src != 4'hf && ext_reset_src[src] === 1'b1))) cnt = 0;
      repeat (10) @(posedge pclk);
      chk("count_value", cnt, {24'h0, count_value});
      chk("period_match count", pm_exp, pm_seen);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {timer_input_clock, ext_reset_pin, sleep_mode} = '0;
      d = $urandom(32'h6ae1);
      ext_reset_src = 14'($urandom);
      per = 255;
      src = 4'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) rd(ofs[i], rv[i], 1'b0);
      rd(8'h14, 32'h0, 1'b1);
      d = $urandom;
      wr(8'h10, d);
      rd(8'h10, d & 32'hf, 1'b0);
      wr(8'h00, d);
      rd(8'h00, d & 32'hff, 1'b0);
      wr(8'h0c, d);
      rd(8'h0c, 32'h0, 1'b0);
      wr(8'h10, 32'h0);
      cfg(8'h00);
      per = 2;
      wr(8'h08, 32'h2);
      setrun(1);
      repeat (7) tick;
      rd(8'h0c, cnt, 1'b0);
      setrun(0);
      repeat (4) tick;
      cfg(8'h40);
      setrun(1);
      repeat (6) tick;
      setrun(0);
      cfg(8'h80);
      slp = 1;
      sleep_mode <= 1'b1;
      setrun(1);
      repeat (4) tick;
      slp = 0;
      sleep_mode <= 1'b0;
      repeat (4) tick;
      setrun(0);
      cfg(8'h08);
      setrun(1);
      repeat (8) tick;
      rd(8'h04, {31'h0, run}, 1'b0);
      cfg(8'h04);
      ext_reset_src <= 14'($urandom);
      setrun(1);
      repeat (3) tick;
      ext_reset_pin <= 1'b1;
      repeat (3) tick;
      ext_reset_pin <= 1'b0;
      wr(8'h10, 32'hf);
      src = 4'hf;
      ext_reset_pin <= 1'b1;
      repeat (3) tick;
      ext_reset_pin <= 1'b0;
      src = 4'(1 + $urandom % 14);
      wr(8'h10, {28'h0, src});
      ext_reset_src <= 14'(1 << (src - 1));
      repeat (3) tick;
      ext_reset_src <= ~14'(1 << (src - 1));
      repeat (3) tick;
      setrun(0);
      cfg(8'h20);
      setrun(1);
      repeat (6) tick;
      conclude();
   end
endmodule // testbench
